// ---- pkg/blsr_pkg.sv ----
// Constants for the block lock and parameter-header read logic of a serial flash.
// Assumes a single system clock much faster than the serial clock.
`default_nettype none
package blsr_pkg;
    // Opcodes
    localparam logic [7:0] OP_WRITE_ENABLE  = 8'h06;
    localparam logic [7:0] OP_SINGLE_LOCK   = 8'h36;
    localparam logic [7:0] OP_SINGLE_UNLOCK = 8'h39;
    localparam logic [7:0] OP_LOCK_STATUS   = 8'h3C;
    localparam logic [7:0] OP_WHOLE_LOCK    = 8'h7E;
    localparam logic [7:0] OP_WHOLE_UNLOCK  = 8'h98;
    localparam logic [7:0] OP_PARAM_READ    = 8'h5A;

    // Frame shape, in whole bytes including the opcode, and the last bit index within a byte
    localparam logic [2:0] BYTES_OPCODE_ONLY = 3'd1;
    localparam logic [2:0] BYTES_WITH_ADDR   = 3'd4;
    localparam logic [2:0] BYTES_WITH_DUMMY  = 3'd5;
    localparam logic [2:0] BIT_LAST          = 3'd7;

    // Lock map: one bit per 64 KiB block of a 1 MiB array
    localparam int         NUM_BLOCKS = 16;
    localparam int         BLK_LSB    = 16;
    localparam int         BLK_MSB    = 19;
    localparam logic [15:0] LOCK_RESET = 16'h0000;

    // Parameter header area
    localparam logic [23:0] HDR_LAST     = 24'h00_0017;
    localparam logic [7:0]  HDR_FILL     = 8'hFF;
    localparam logic [7:0]  SIG_B0       = 8'h53;
    localparam logic [7:0]  SIG_B1       = 8'h46;
    localparam logic [7:0]  SIG_B2       = 8'h44;
    localparam logic [7:0]  SIG_B3       = 8'h50;
    localparam logic [7:0]  REV_MINOR    = 8'h00;
    localparam logic [7:0]  REV_MAJOR    = 8'h01;
    localparam logic [7:0]  HDR_COUNT    = 8'h01;
    localparam logic [7:0]  HDR0_ID      = 8'h00;
    localparam logic [7:0]  HDR0_LEN     = 8'h09;
    localparam logic [7:0]  HDR0_PTR     = 8'h30;
    localparam logic [7:0]  HDR1_LEN     = 8'h04;
    localparam logic [7:0]  HDR1_PTR     = 8'h60;
    localparam logic [7:0]  PTR_UPPER    = 8'h00;
endpackage
`default_nettype wire

// ---- rtl/blsr_param_rom.sv ----
// Parameter header table: signature, revision, header count and two headers.
// Purely combinational; the caller registers the byte before it leaves the block.
`timescale 1ns/100ps
`default_nettype none
module blsr_param_rom #(
    parameter logic [7:0] VENDOR_ID = 8'h5A  // Arbitrary value
)(
    input  wire logic [23:0] addr,
    output logic      [7:0]  data
);
    always_comb
    begin
        data = blsr_pkg::HDR_FILL;
        if (addr <= blsr_pkg::HDR_LAST)
        begin
            case (addr[4:0])
                5'h00:   data = blsr_pkg::SIG_B0;
                5'h01:   data = blsr_pkg::SIG_B1;
                5'h02:   data = blsr_pkg::SIG_B2;
                5'h03:   data = blsr_pkg::SIG_B3;
                5'h04:   data = blsr_pkg::REV_MINOR;
                5'h05:   data = blsr_pkg::REV_MAJOR;
                5'h06:   data = blsr_pkg::HDR_COUNT;
                5'h08:   data = blsr_pkg::HDR0_ID;
                5'h09:   data = blsr_pkg::REV_MINOR;
                5'h0A:   data = blsr_pkg::REV_MAJOR;
                5'h0B:   data = blsr_pkg::HDR0_LEN;
                5'h0C:   data = blsr_pkg::HDR0_PTR;
                5'h0D:   data = blsr_pkg::PTR_UPPER;
                5'h0E:   data = blsr_pkg::PTR_UPPER;
                5'h10:   data = VENDOR_ID;
                5'h11:   data = blsr_pkg::REV_MINOR;
                5'h12:   data = blsr_pkg::REV_MAJOR;
                5'h13:   data = blsr_pkg::HDR1_LEN;
                5'h14:   data = blsr_pkg::HDR1_PTR;
                5'h15:   data = blsr_pkg::PTR_UPPER;
                5'h16:   data = blsr_pkg::PTR_UPPER;
                default: data = blsr_pkg::HDR_FILL;
            endcase
        end
    end
endmodule
`default_nettype wire

// ---- rtl/blsr_top.sv ----
// Serial-flash command slice: per-block write locks and the parameter header read.
// Assumes csN, sclk and serialIn come from pins and that sclk is at most clk/8.
`timescale 1ns/100ps
`default_nettype none
module blsr_top (
    input  wire logic        clk,
    input  wire logic        reset_n,
    input  wire logic        csN,
    input  wire logic        sclk,
    input  wire logic        serialIn,
    input  wire logic        protectModeSelect,
    input  wire logic        progEraseReq,
    input  wire logic [23:0] progEraseAddr,
    output logic             serialOut,
    output logic             serialOutEnN,
    output logic             progEraseGrant,
    output logic             progEraseDenied,
    output logic      [15:0] lockMap
);
    localparam int NB = blsr_pkg::NUM_BLOCKS;

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers; the third stage only feeds edge detection
    logic        csS1_reg, csS2_reg, csS3_reg;
    logic        sclkS1_reg, sclkS2_reg, sclkS3_reg;
    logic        siS1_reg, siS2_reg;

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            {csS1_reg, csS2_reg, csS3_reg}       <= 3'b111;
            {sclkS1_reg, sclkS2_reg, sclkS3_reg} <= 3'b000;
            {siS1_reg, siS2_reg}                 <= 2'b00;
        end
        else
        begin
            {csS1_reg, csS2_reg, csS3_reg}       <= {csN, csS1_reg, csS2_reg};
            {sclkS1_reg, sclkS2_reg, sclkS3_reg} <= {sclk, sclkS1_reg, sclkS2_reg};
            {siS1_reg, siS2_reg}                 <= {serialIn, siS1_reg};
        end
    end

    wire inFrame = ~csS2_reg;
    wire csRise  = csS2_reg & ~csS3_reg;
    wire sRise   = inFrame & sclkS2_reg & ~sclkS3_reg;
    wire sFall   = inFrame & ~sclkS2_reg & sclkS3_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Input shifter and frame counters
    logic [7:0]  rxShift_reg;
    logic [2:0]  bitCnt_reg;
    logic [2:0]  byteCnt_reg;
    logic [7:0]  opcode_reg;
    logic [23:0] addr_reg;
    logic [7:0]  outShift_reg;
    logic [2:0]  outCnt_reg;
    logic        outPhase_reg;
    logic        loadOut_reg;
    logic        weLatch_reg;
    logic        startPending_reg;
    logic [NB-1:0] lockBits_reg;

    wire [7:0] rxByte   = {rxShift_reg[6:0], siS2_reg};
    wire       byteDone = sRise && (bitCnt_reg == blsr_pkg::BIT_LAST);
    wire       modeOn   = protectModeSelect;
    wire       isStatus = (opcode_reg == blsr_pkg::OP_LOCK_STATUS);
    wire       isParam  = (opcode_reg == blsr_pkg::OP_PARAM_READ);

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rxShift_reg <= 8'h00;
            bitCnt_reg  <= 3'd0;
            byteCnt_reg <= 3'd0;
            opcode_reg  <= 8'h00;
        end
        else if (!inFrame)
        begin
            bitCnt_reg  <= 3'd0;
            byteCnt_reg <= 3'd0;
        end
        else if (sRise)
        begin
            rxShift_reg <= rxByte;
            bitCnt_reg  <= bitCnt_reg + 3'd1;
            if (byteDone && byteCnt_reg == 3'd0)
                opcode_reg <= rxByte;
            if (byteDone && byteCnt_reg != 3'd7)
                byteCnt_reg <= byteCnt_reg + 3'd1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Command decode at the rising chip select edge
    wire onBoundary   = (bitCnt_reg == 3'd0);
    wire addrFrame    = onBoundary && (byteCnt_reg == blsr_pkg::BYTES_WITH_ADDR);
    wire bareFrame    = onBoundary && (byteCnt_reg == blsr_pkg::BYTES_OPCODE_ONLY);
    wire armed        = csRise && modeOn && weLatch_reg;
    wire singleLock   = armed && addrFrame && (opcode_reg == blsr_pkg::OP_SINGLE_LOCK);
    wire singleUnlock = armed && addrFrame && (opcode_reg == blsr_pkg::OP_SINGLE_UNLOCK);
    wire wholeLock    = armed && bareFrame && (opcode_reg == blsr_pkg::OP_WHOLE_LOCK);
    wire wholeUnlock  = armed && bareFrame && (opcode_reg == blsr_pkg::OP_WHOLE_UNLOCK);
    wire anyLockCmd   = singleLock | singleUnlock | wholeLock | wholeUnlock;
    wire weCmd        = csRise && bareFrame && (opcode_reg == blsr_pkg::OP_WRITE_ENABLE);
    wire [3:0] blkIdx = addr_reg[blsr_pkg::BLK_MSB:blsr_pkg::BLK_LSB];

    // Write enable is consumed by the command it armed, as the host is expected to resend it
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            weLatch_reg <= 1'b0;
        else if (weCmd)
            weLatch_reg <= 1'b1;
        else if (anyLockCmd)
            weLatch_reg <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Lock map; startup state is taken one clock after reset release
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            startPending_reg <= 1'b1;
        else
            startPending_reg <= 1'b0;
    end

    genvar gi;
    generate
        for (gi = 0; gi < NB; gi++)
        begin : g_lock
            wire hit = (blkIdx == 4'(gi));
            always_ff @(posedge clk or negedge reset_n)
            begin
                if (!reset_n)
                    lockBits_reg[gi] <= blsr_pkg::LOCK_RESET[gi];
                else if (startPending_reg)
                    lockBits_reg[gi] <= modeOn;
                else if (wholeLock || (singleLock && hit))
                    lockBits_reg[gi] <= 1'b1;
                else if (wholeUnlock || (singleUnlock && hit))
                    lockBits_reg[gi] <= 1'b0;
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Address capture and output shifting
    logic [7:0] romByte;

    blsr_param_rom u_rom (
        .addr (addr_reg),
        .data (romByte)
    );

    wire lastHdrByte = byteDone && ((isStatus && modeOn && byteCnt_reg == blsr_pkg::BYTES_WITH_ADDR - 3'd1) ||
                                    (isParam && byteCnt_reg == blsr_pkg::BYTES_WITH_DUMMY - 3'd1));
    wire reload      = sFall && outPhase_reg && (outCnt_reg == blsr_pkg::BIT_LAST);
    wire [7:0] outData = isStatus ? {7'b000_0000, lockBits_reg[blkIdx]} : romByte;

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            addr_reg <= 24'h00_0000;
        else if (byteDone && byteCnt_reg >= 3'd1 && byteCnt_reg <= 3'd3)
            addr_reg <= {addr_reg[15:0], rxByte};
        else if (reload && isParam)
            addr_reg <= addr_reg + 24'h00_0001;
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            loadOut_reg <= 1'b0;
        else
            loadOut_reg <= lastHdrByte || reload;
    end

    // Slow serial clock leaves a spare system cycle to fetch the next byte
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            outPhase_reg <= 1'b0;
            outShift_reg <= 8'h00;
            outCnt_reg   <= 3'd0;
        end
        else if (!inFrame)
            outPhase_reg <= 1'b0;
        else if (loadOut_reg)
        begin
            outPhase_reg <= 1'b1;
            outShift_reg <= outData;
            outCnt_reg   <= 3'd0;
        end
        else if (sFall && outPhase_reg)
        begin
            outShift_reg <= {outShift_reg[6:0], 1'b1};
            outCnt_reg   <= outCnt_reg + 3'd1;
        end
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            serialOut    <= 1'b0;
            serialOutEnN <= 1'b1;
        end
        else
        begin
            if (sFall && outPhase_reg)
                serialOut <= outShift_reg[7];
            serialOutEnN <= ~(outPhase_reg && inFrame);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Program and erase gate; of the reads only the lock status read consults the lock map, parameter reads never do
    wire reqLocked = modeOn && lockBits_reg[progEraseAddr[blsr_pkg::BLK_MSB:blsr_pkg::BLK_LSB]];

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            progEraseGrant  <= 1'b0;
            progEraseDenied <= 1'b0;
            lockMap         <= blsr_pkg::LOCK_RESET;
        end
        else
        begin
            progEraseGrant  <= progEraseReq && !reqLocked;
            progEraseDenied <= progEraseReq && reqLocked;
            lockMap         <= lockBits_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    sequence sLockDone;
        singleLock;
    endsequence
    sequence sStatusLoad;
        loadOut_reg && isStatus && !outPhase_reg;
    endsequence

    a_single_lock:   assert property (sLockDone |=> lockBits_reg[$past(blkIdx)])
        else $error("single lock did not set block");
    a_single_unlock: assert property (singleUnlock |=>
                         lockBits_reg == ($past(lockBits_reg) & ~(16'h0001 << $past(blkIdx))))
        else $error("single unlock changed wrong bits");
    a_off_boundary:  assert property (csRise && !onBoundary && !startPending_reg |=> $stable(lockBits_reg))
        else $error("misaligned frame changed locks");
    a_mode_off:      assert property (!modeOn && !startPending_reg |=> $stable(lockBits_reg))
        else $error("locks changed outside protect mode");
    a_whole_chip:    assert property (wholeLock |=> &lockBits_reg ##0 lockMap == $past(lockMap))
        else $error("whole lock not applied");
    a_deny_locked:   assert property (progEraseReq && reqLocked |=> progEraseDenied && !progEraseGrant)
        else $error("locked block not refused");
    a_so_release:    assert property (csS2_reg |=> serialOutEnN)
        else $error("output still driven after frame end");
    a_start_locked:  assert property (startPending_reg && modeOn |=> &lockBits_reg ##1 &lockMap)
        else $error("startup lock state wrong");
    a_status_byte:   assert property (sStatusLoad |=> outShift_reg[7:1] == 7'h00 && outShift_reg[0] == $past(lockBits_reg[blkIdx]))
        else $error("status byte wrong");
endmodule
`default_nettype wire

// ---- tb/blsr_host_model.sv ----
// Host serial controller that frames commands with csN and clocks answers back.
// Assumes the block samples on sclk rise and shifts out after sclk fall.
`timescale 1ns/100ps
`default_nettype none
module blsr_host_model (
    input  wire logic clk,
    input  wire logic serialOut,
    input  wire logic serialOutEnN,
    output var  logic csN,
    output var  logic sclk,
    output var  logic serialIn
);
    logic [7:0] rxByte [0:31];
    logic       enSeen;

    initial
    begin
        csN = 1'b1;
        sclk = 1'b0;
        serialIn = 1'b0;
        enSeen = 1'b0;
    end

    // Eight clocks per half period keeps sclk well under clk/8
    task automatic half();
        repeat (8) @(posedge clk);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // nTx bits of tx leave MSB first, then nRx bytes are clocked back
    task automatic frame(input logic [39:0] tx, input int nTx, input int nRx);
        logic [7:0] b;
        b = 8'h00;
        enSeen = 1'b0;
        @(posedge clk);
        csN <= 1'b0;
        half();
        for (int i = 0; i < nTx; i++)
        begin
            serialIn <= tx[39 - i];
            half();
            sclk <= 1'b1;
            half();
            sclk <= 1'b0;
        end
        for (int k = 0; k < nRx; k++)
        begin
            for (int j = 0; j < 8; j++)
            begin
                // Input toggles so no stale level lingers while the block talks
                serialIn <= ~serialIn;
                half();
                @(negedge clk);
                // A released line reads inverted, so a late output enable shows up as bad data
                b = {b[6:0], serialOutEnN ? ~serialOut : serialOut};
                enSeen = enSeen | (serialOutEnN === 1'b0);
                @(posedge clk);
                sclk <= 1'b1;
                half();
                sclk <= 1'b0;
            end
            rxByte[k] = b;
        end
        half();
        csN <= 1'b1;
        serialIn <= ~serialIn;
        half();
    endtask

    task automatic command(input logic [7:0] op, input logic [23:0] addr, input int nTx, input bit write_enable_cmd);
        if (write_enable_cmd)
            frame({blsr_pkg::OP_WRITE_ENABLE, 32'h0000_0000}, 8, 0);
        frame({op, addr, 8'h00}, nTx, 0);
    endtask
endmodule
`default_nettype wire

// ---- tb/tb.sv ----
// Self-checking bench for the block lock and parameter-header slice.
// Assumes the host model file is compiled before this one.
`timescale 1ns/100ps
`default_nettype none
module tb;
    logic        clk;
    logic        reset_n;
    logic        protectModeSelect;
    logic        progEraseReq;
    logic [23:0] progEraseAddr;
    wire logic   csN;
    wire logic   sclk;
    wire logic   serialIn;
    wire logic   serialOut;
    wire logic   serialOutEnN;
    wire logic   progEraseGrant;
    wire logic   progEraseDenied;
    wire logic [15:0] lockMap;
    int          err_count = 0;
    int          comparisons = 0;
    localparam logic [191:0] PTAB = 192'h5346_4450_0001_01FF_0000_0109_3000_00FF_0000_0104_6000_00FF;

    blsr_top dut (.clk(clk), .reset_n(reset_n), .csN(csN), .sclk(sclk), .serialIn(serialIn),
        .protectModeSelect(protectModeSelect), .progEraseReq(progEraseReq), .progEraseAddr(progEraseAddr),
        .serialOut(serialOut), .serialOutEnN(serialOutEnN), .progEraseGrant(progEraseGrant),
        .progEraseDenied(progEraseDenied), .lockMap(lockMap));
    blsr_host_model host (.clk(clk), .serialOut(serialOut), .serialOutEnN(serialOutEnN),
        .csN(csN), .sclk(sclk), .serialIn(serialIn));

    initial clk = 1'b0;
    always #5 clk = ~clk;

    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
        comparisons++;
        if (seen !== exp)
        begin
            err_count++;
            $display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    task automatic restart(input logic pms);
        @(posedge clk);
        protectModeSelect <= pms;
        reset_n <= 1'b0;
        repeat (3) @(posedge clk);
        reset_n <= 1'b1;
        repeat (6) @(posedge clk);
    endtask

    // Expected two bits are {grant, denied}
    task automatic gate(input logic [23:0] a, input logic [1:0] exp, input string what);
        @(posedge clk);
        progEraseReq <= 1'b1;
        progEraseAddr <= a;
        @(posedge clk);
        progEraseReq <= 1'b0;
        @(negedge clk);
        check({14'h0000, progEraseGrant, progEraseDenied}, {14'h0000, exp}, what);
    endtask

    task automatic status(input logic [23:0] a, input logic [7:0] exp);
        host.frame({blsr_pkg::OP_LOCK_STATUS, a, 8'h00}, 32, 2);
        check({host.rxByte[1], host.rxByte[0]}, {exp, exp}, "lock status");
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task automatic test_unprotected();
        restart(1'b0);
        check(lockMap, 16'h0000, "map after plain reset");
        host.command(blsr_pkg::OP_SINGLE_LOCK, 24'h03_0000, 32, 1'b1);
        host.command(blsr_pkg::OP_WHOLE_LOCK, 24'h00_0000, 8, 1'b1);
        check(lockMap, 16'h0000, "locks without protect mode");
        host.frame({blsr_pkg::OP_LOCK_STATUS, 24'h03_0000, 8'h00}, 32, 1);
        check({15'h0000, host.enSeen}, 16'h0000, "status output without protect mode");
        $display("test unprotected done");
    endtask

    task automatic test_locks();
        restart(1'b1);
        check(lockMap, 16'hFFFF, "map after protected reset");
        gate(24'h02_0000, 2'b01, "erase to locked block");
        host.command(blsr_pkg::OP_WHOLE_UNLOCK, 24'h00_0000, 8, 1'b1);
        check(lockMap, 16'h0000, "whole unlock");
        host.command(blsr_pkg::OP_SINGLE_LOCK, 24'h05_1234, 32, 1'b1);
        host.command(blsr_pkg::OP_SINGLE_LOCK, 24'h0F_FFFF, 32, 1'b1);
        check(lockMap, 16'h8020, "two single locks");
        host.command(blsr_pkg::OP_SINGLE_UNLOCK, 24'h05_0000, 32, 1'b1);
        check(lockMap, 16'h8000, "single unlock");
        host.command(blsr_pkg::OP_SINGLE_LOCK, 24'h01_0000, 32, 1'b0);
        check(lockMap, 16'h8000, "lock without write enable");
        host.command(blsr_pkg::OP_SINGLE_LOCK, 24'h01_0000, 28, 1'b1);
        host.command(blsr_pkg::OP_WHOLE_LOCK, 24'h00_0000, 12, 1'b1);
        check(lockMap, 16'h8000, "frames off byte boundary");
        status(24'h0F_0000, 8'h01);
        status(24'h05_0000, 8'h00);
        gate(24'h0F_8000, 2'b01, "program to locked block");
        gate(24'h05_0000, 2'b10, "program to open block");
        host.command(blsr_pkg::OP_WHOLE_LOCK, 24'h00_0000, 8, 1'b1);
        check(lockMap, 16'hFFFF, "whole lock");
        $display("test locks done");
    endtask

    task automatic test_param();
        host.frame({blsr_pkg::OP_PARAM_READ, 24'h00_0000, 8'hA5}, 40, 24);
        for (int i = 0; i < 24; i++)
            if (i != 16)
                check({8'h00, host.rxByte[i]}, {8'h00, PTAB[191 - 8 * i -: 8]}, "header byte");
        check({15'h0000, host.enSeen}, 16'h0001, "output enabled");
        check({15'h0000, serialOutEnN}, 16'h0001, "output released");
        host.frame({blsr_pkg::OP_PARAM_READ, 24'h00_0016, 8'h00}, 40, 3);
        check({host.rxByte[0], host.rxByte[1]}, 16'h00FF, "tail bytes");
        check({8'h00, host.rxByte[2]}, 16'h00FF, "past the headers");
        check({15'h0000, serialOutEnN}, 16'h0001, "early stop released");
        $display("test param done");
    endtask

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    initial
    begin
        reset_n = 1'b0;
        protectModeSelect = 1'b0;
        progEraseReq = 1'b0;
        progEraseAddr = 24'h00_0000;
        test_unprotected();
        test_locks();
        test_param();
        tally_and_finish();
    end

    // The tests need roughly 12500 cycles; nearly five times that means a hang
    initial
    begin
        repeat (60000) @(posedge clk);
        err_count++;
        tally_and_finish();
    end
endmodule
`default_nettype wire
